//--- dv/rcs_run_command_source_select_sva.sv
// Checker for the run command source selector outputs.
// Assumes binding to the top module; every input belongs to clk.
`timescale 1ns/1ps
module rcs_run_command_source_select_sva (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [1:0] commandSourceSelect,
  input wire logic       runKey,
  input wire logic       stopKey,
  input wire logic       commStart,
  input wire logic       commStop,
  input wire logic       otherStop,
  input wire logic       driveRun,
  input wire logic       driveJog,
  input wire logic       runIndicator
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic keySel;
  logic linkSel;
  assign keySel  = commandSourceSelect == 2'h0;
  assign linkSel = commandSourceSelect == 2'h2;
  a_lamp_tracks_run: assert property (runIndicator == driveRun)
    else $error("run lamp differs from run state");
  a_key_starts: assert property (keySel && runKey && !stopKey && !otherStop |=> driveRun)
    else $error("run key did not start");
  a_key_stops: assert property (keySel && stopKey && !runKey && driveRun |=> !driveRun)
    else $error("stop key did not stop");
  a_link_starts: assert property (linkSel && commStart && !commStop && !otherStop |=> driveRun)
    else $error("link start ignored");
  a_link_stops: assert property (linkSel && commStop |=> !driveRun)
    else $error("link stop ignored");
  a_unselected_quiet: assert property (keySel && !runKey && !driveRun |=> !driveRun)
    else $error("start from unselected source");
  a_forced_stop: assert property (commandSourceSelect == 2'h3 |=> !driveRun)
    else $error("source three left drive running");
  a_jog_when_idle: assert property (driveJog |-> !driveRun)
    else $error("jog while running");
  cover property (keySel && runKey ##1 driveRun);
  cover property (linkSel && commStart ##1 driveRun);
  cover property (commandSourceSelect == 2'h1 && driveRun);
endmodule

bind rcs_run_command_source_select rcs_run_command_source_select_sva chk_u (.clk(clk),
  .reset(reset), .commandSourceSelect(commandSourceSelect), .runKey(runKey),
  .stopKey(stopKey), .commStart(commStart), .commStop(commStop), .otherStop(otherStop),
  .driveRun(driveRun), .driveJog(driveJog), .runIndicator(runIndicator));

//--- dv/rcs_run_command_source_select_test.sv
// Bench for the run command source selector with a terminal model.
// Assumes default input count and no link jog or link reverse traffic.
`timescale 1ns/1ps
module rcs_run_command_source_select_test;
  logic [1:0]  src = 2'h0;
  logic [1:0]  sch = 2'h0;
  logic [62:0] fsel;
  logic [2:0]  want = 3'h0;
  logic [4:0]  keys = 5'h00;
  logic [8:0]  pins;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        run, reverse_run_input, pRun, pRev;
  logic        jog, coast, frst, lamp;
  logic [1:0]  e;
  logic [1:0]  q[$];
  int          errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  initial forever #50 clk = ~clk;
  rcs_run_command_source_select dut_u (.clk(clk), .reset(reset),
    .commandSourceSelect(src), .terminalSchemeSelect(sch), .inputFunctionSelect(fsel),
    .multifunctionInputs(pins), .runKey(keys[0]), .stopKey(keys[1]), .commStart(keys[2]),
    .commStop(keys[3]), .commReverse(1'b0), .commJog(1'b0), .otherStop(keys[4]),
    .driveRun(run), .driveReverse(reverse_run_input), .driveJog(jog), .driveCoast(coast),
    .driveFaultReset(frst), .runIndicator(lamp));
  rcs_term_partner part_u (.clk(clk), .want(want), .pins(pins));
  ////////////////////////////////////////
  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One-cycle key pulse, new pin levels, optional note of the next output change
  task automatic step(input logic [4:0] k, input logic [2:0] w, input bit p,
                      input logic [1:0] e);
    if (p) q.push_back(e);
    keys = k;
    want = w;
    @(negedge clk);
    keys = 5'h00;
    repeat (8) @(negedge clk);
  endtask
  ////////////////////////////////////////
  always @(negedge clk) begin
    if (!reset && (run !== pRun || (run && reverse_run_input !== pRev))) begin
      if (q.size() == 0) check({run, reverse_run_input}, 2'hx);
      else begin
        e = q.pop_front();
        check({run, run & reverse_run_input}, e);
        check({1'b0, lamp}, {1'b0, e[1]});
      end
    end
    pRun = run;
    pRev = reverse_run_input;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(32'h2e02800b));
    fsel = 63'h0;
    for (int i = 3; i < 9; i++) fsel[i*7+:7] = 7'(8 + $urandom % 88);
    fsel[20:0] = {7'h03, 7'h02, 7'h01};
    repeat (12) @(negedge clk);
    reset = 1'b0;
    step(5'h01, 3'h0, 1, 2'h2);
    step(5'h02, 3'h0, 1, 2'h0);
    step(5'h04, 3'h1, 0, 2'h0);
    src = 2'h2;
    step(5'h04, 3'h0, 1, 2'h2);
    step(5'h0c, 3'h0, 1, 2'h0);
    step(5'h04, 3'h0, 1, 2'h2);
    src = 2'h3;
    step(5'h00, 3'h0, 1, 2'h0);
    src = 2'h1;
    step(5'h00, 3'h1, 1, 2'h2);
    step(5'h00, 3'h0, 1, 2'h0);
    step(5'h00, 3'h2, 1, 2'h3);
    step(5'h00, 3'h0, 1, 2'h0);
    step(5'h00, 3'h1, 1, 2'h2);
    step(5'h10, 3'h1, 1, 2'h0);
    step(5'h00, 3'h1, 0, 2'h0);
    step(5'h00, 3'h0, 0, 2'h0);
    step(5'h00, 3'h1, 1, 2'h2);
    step(5'h00, 3'h0, 1, 2'h0);
    sch = 2'h1;
    step(5'h00, 3'h2, 0, 2'h0);
    step(5'h00, 3'h3, 1, 2'h3);
    step(5'h00, 3'h0, 1, 2'h0);
    sch = 2'h2;
    step(5'h00, 3'h4, 0, 2'h0);
    step(5'h00, 3'h5, 1, 2'h2);
    step(5'h00, 3'h6, 1, 2'h3);
    step(5'h00, 3'h4, 1, 2'h2);
    step(5'h00, 3'h0, 1, 2'h0);
    sch = 2'h3;
    step(5'h00, 3'h4, 0, 2'h0);
    step(5'h00, 3'h5, 1, 2'h2);
    step(5'h00, 3'h4, 0, 2'h0);
    step(5'h00, 3'h6, 1, 2'h3);
    step(5'h00, 3'h2, 1, 2'h0);
    fsel[20:14] = 7'h05;
    step(5'h00, 3'h4, 0, 2'h0);
    check({jog, reverse_run_input}, 2'h3);
    fsel[20:14] = 7'h06;
    step(5'h00, 3'h4, 0, 2'h0);
    check({coast, frst}, 2'h2);
    fsel[20:14] = 7'h07;
    step(5'h00, 3'h4, 0, 2'h0);
    check({coast, frst}, 2'h1);
    check({jog, run}, 2'h0);
    step(5'h00, 3'h0, 0, 2'h0);
    check(2'(q.size()), 2'h0);
    give_verdict();
  end
endmodule

//--- dv/rcs_term_partner.sv
// Terminal wiring model: switches on pins 0-2, noisy spare pins above.
// Assumes the bench maps fwd, rev and enable to pins 0, 1 and 2.
`timescale 1ns/1ps
module rcs_term_partner (
  input  wire logic       clk,
  input  wire logic [2:0] want,
  output logic      [8:0] pins
);
  initial pins = 9'h000;
  // Enable held closed for as long as the bench sets want bit 2
  always @(posedge clk) begin
    pins <= {6'($urandom), want};
  end
endmodule

//--- hdl/rcs_run_command_source_select.sv
// Run command source selector: keypad, terminals or link drive run state.
// Assumes synchronous settings from the same clock; terminal pins are async.
`timescale 1ns/1ps
`include "rcs_defs.svh"
module rcs_run_command_source_select #(
  parameter int NUM_IN = `RCS_NUM_INPUTS
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic [1:0]             commandSourceSelect,
  input  wire logic [1:0]             terminalSchemeSelect,
  input  wire logic [NUM_IN*7-1:0]    inputFunctionSelect,
  input  wire logic [NUM_IN-1:0]      multifunctionInputs,
  input  wire logic                   runKey,
  input  wire logic                   stopKey,
  input  wire logic                   commStart,
  input  wire logic                   commStop,
  input  wire logic                   commReverse,
  input  wire logic                   commJog,
  input  wire logic                   otherStop,
  output logic                        driveRun,
  output logic                        driveReverse,
  output logic                        driveJog,
  output logic                        driveCoast,
  output logic                        driveFaultReset,
  output logic                        runIndicator
);

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge history
  logic [NUM_IN-1:0] pinMeta_reg;
  logic [NUM_IN-1:0] pinMeta_next;
  logic [NUM_IN-1:0] pinSync_reg;
  logic [NUM_IN-1:0] pinSync_next;
  rcs_pkg::rcs_term_s termPrev_reg;
  rcs_pkg::rcs_term_s termPrev_next;
  rcs_pkg::rcs_term_s term;

  always_comb begin
    pinMeta_next = multifunctionInputs;
    pinSync_next = pinMeta_reg;
    termPrev_next = term;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pinMeta_reg <= '0;
      pinSync_reg <= '0;
      termPrev_reg <= '0;
    end else begin
      pinMeta_reg <= pinMeta_next;
      pinSync_reg <= pinSync_next;
      termPrev_reg <= termPrev_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Map each input to its function; codes outside 1-7 add nothing
  always_comb begin
    rcs_pkg::rcs_func_t fn;
    fn = '0;
    term = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      fn = inputFunctionSelect[i*7 +: 7];
      if (pinSync_reg[i]) begin
        unique case (fn)
          `RCS_FN_FWD:    term.forward_run_input = 1'b1;
          `RCS_FN_REV:    term.reverse_run_input = 1'b1;
          `RCS_FN_3WEN:   term.en3 = 1'b1;
          `RCS_FN_JOGF:   term.jogF = 1'b1;
          `RCS_FN_JOGR:   term.jogR = 1'b1;
          `RCS_FN_COAST:  term.coast = 1'b1;
          `RCS_FN_FRESET: term.faultReset = 1'b1;
          default: ;
        endcase
      end
    end
  end

  wire logic fwdRise = term.forward_run_input & ~termPrev_reg.forward_run_input;
  wire logic revRise = term.reverse_run_input & ~termPrev_reg.reverse_run_input;
  wire logic revChg  = term.reverse_run_input ^ termPrev_reg.reverse_run_input;

  //////////////////////////////////////////////////////////////////////
  // Run state
  rcs_pkg::rcs_state_e state_reg;
  rcs_pkg::rcs_state_e state_next;
  logic rev_reg;
  logic rev_next;
  logic lockout_reg;
  logic lockout_next;
  rcs_pkg::rcs_cmd_s out_reg;
  rcs_pkg::rcs_cmd_s out_next;

  always_comb begin
    logic twoWire;
    logic want;
    logic wantRev;
    twoWire = (terminalSchemeSelect == `RCS_SCH_2W1) ||
              (terminalSchemeSelect == `RCS_SCH_2W2);
    want = 1'b0;
    wantRev = 1'b0;
    state_next = state_reg;
    rev_next = rev_reg;
    lockout_next = lockout_reg;
    out_next = '0;
    unique case (commandSourceSelect)
      `RCS_SRC_KEYPAD: begin
        lockout_next = 1'b0;
        if (state_reg == rcs_pkg::RCS_RUNNING && (stopKey || otherStop)) begin
          state_next = rcs_pkg::RCS_STOPPED;
        end else if (state_reg == rcs_pkg::RCS_STOPPED && runKey) begin
          state_next = rcs_pkg::RCS_RUNNING;
          rev_next = 1'b0;
        end
      end
      `RCS_SRC_COMM: begin
        lockout_next = 1'b0;
        if (commStop || otherStop) begin
          state_next = rcs_pkg::RCS_STOPPED;
        end else if (commStart) begin
          state_next = rcs_pkg::RCS_RUNNING;
          rev_next = commReverse;
        end
      end
      `RCS_SRC_TERMINAL: begin
        if (twoWire) begin
          if (terminalSchemeSelect == `RCS_SCH_2W1) begin
            want = term.forward_run_input ^ term.reverse_run_input;
            wantRev = term.reverse_run_input;
          end else begin
            want = term.forward_run_input;
            wantRev = term.reverse_run_input;
          end
          if (!want) begin
            lockout_next = 1'b0;
          end else if (otherStop || stopKey) begin
            lockout_next = 1'b1;
          end
          if (want && !lockout_reg && !otherStop && !stopKey) begin
            state_next = rcs_pkg::RCS_RUNNING;
            rev_next = wantRev;
          end else begin
            state_next = rcs_pkg::RCS_STOPPED;
          end
        end else begin
          lockout_next = 1'b0;
          if (!term.en3 || otherStop) begin
            state_next = rcs_pkg::RCS_STOPPED;
          end else if (terminalSchemeSelect == `RCS_SCH_3W1) begin
            if (state_reg == rcs_pkg::RCS_STOPPED && fwdRise) begin
              state_next = rcs_pkg::RCS_RUNNING;
              rev_next = term.reverse_run_input;
            end else if (state_reg == rcs_pkg::RCS_RUNNING && revChg) begin
              rev_next = ~rev_reg;
            end
          end else begin
            if (fwdRise) begin
              state_next = rcs_pkg::RCS_RUNNING;
              rev_next = 1'b0;
            end else if (revRise) begin
              state_next = rcs_pkg::RCS_RUNNING;
              rev_next = 1'b1;
            end
          end
        end
      end
      default: state_next = rcs_pkg::RCS_STOPPED;
    endcase
    // Jog only from the selected source while not running
    if (state_next == rcs_pkg::RCS_STOPPED) begin
      if (commandSourceSelect == `RCS_SRC_TERMINAL && (term.jogF ^ term.jogR)) begin
        out_next.jog = 1'b1;
        out_next.reverse = term.jogR;
      end else if (commandSourceSelect == `RCS_SRC_COMM && commJog) begin
        out_next.jog = 1'b1;
        out_next.reverse = commReverse;
      end
    end else begin
      out_next.run = 1'b1;
      out_next.reverse = rev_next;
    end
    if (commandSourceSelect == `RCS_SRC_TERMINAL) begin
      out_next.coast = term.coast;
      out_next.faultReset = term.faultReset;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= rcs_pkg::RCS_STOPPED;
      rev_reg <= 1'b0;
      lockout_reg <= 1'b0;
      out_reg <= '0;
    end else begin
      state_reg <= state_next;
      rev_reg <= rev_next;
      lockout_reg <= lockout_next;
      out_reg <= out_next;
    end
  end

  always_comb begin
    driveRun = out_reg.run;
    driveReverse = out_reg.reverse;
    driveJog = out_reg.jog;
    driveCoast = out_reg.coast;
    driveFaultReset = out_reg.faultReset;
    runIndicator = out_reg.run;
  end

endmodule

//--- inc/rcs_defs.svh
// Constants for the run command source selector.
// Assumes inclusion by package and design; definitions only.
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH
`define RCS_SRC_KEYPAD   2'h0
`define RCS_SRC_TERMINAL 2'h1
`define RCS_SRC_COMM     2'h2
`define RCS_SCH_2W1      2'h0
`define RCS_SCH_2W2      2'h1
`define RCS_SCH_3W1      2'h2
`define RCS_SCH_3W2      2'h3
`define RCS_FN_FWD       7'h01
`define RCS_FN_REV       7'h02
`define RCS_FN_3WEN      7'h03
`define RCS_FN_JOGF      7'h04
`define RCS_FN_JOGR      7'h05
`define RCS_FN_COAST     7'h06
`define RCS_FN_FRESET    7'h07
`define RCS_FN_MAX       7'h5f
`define RCS_NUM_INPUTS   9
`define RCS_SCH_RESET    2'h0
`endif

//--- inc/rcs_pkg.sv
// Types for the run command source selector.
// Assumes rcs_defs.svh is on the include path.
`include "rcs_defs.svh"
package rcs_pkg;
  typedef logic [6:0] rcs_func_t;
  // Decoded terminal requests
  typedef struct packed {
    logic forward_run_input;
    logic reverse_run_input;
    logic en3;
    logic jogF;
    logic jogR;
    logic coast;
    logic faultReset;
  } rcs_term_s;
  // Run command as seen by the drive
  typedef struct packed {
    logic run;
    logic reverse;
    logic jog;
    logic coast;
    logic faultReset;
  } rcs_cmd_s;
  typedef enum logic [1:0] {
    RCS_STOPPED = 2'b01,
    RCS_RUNNING = 2'b10
  } rcs_state_e;
endpackage
